//--- rtl/edid_source_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "edid_src_map.svh"
module edid_source_manager #(
    parameter int IMG_BYTES = 256
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_ddc_scl,
    input wire logic i_ddc_sda,
    output logic o_ddc_sda_o,
    output logic o_ddc_sda_oe,
    input wire logic [1:0] i_mode_sel,
    input wire logic i_mode_ovr_en,
    input wire logic [1:0] i_mode_ovr,
    output logic o_eeprom_en,
    output logic o_img_valid,
    input wire logic i_pwr5v,
    input wire logic i_video_ready,
    output logic o_hpd_o,
    output logic o_hpd_oe,
    input wire logic i_host_wr,
    input wire logic [7:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic [7:0] o_fuse_addr,
    input wire logic [7:0] i_fuse_data,
    output logic o_bc_req,
    output logic [7:0] o_bc_dev,
    output logic [7:0] o_bc_off,
    input wire logic i_bc_done,
    input wire logic i_bc_nak,
    input wire logic i_bc_arb_lost,
    input wire logic [7:0] i_bc_data
);
    localparam logic [7:0] DEV = `DDC_DEV_ADDR;
    localparam logic [7:0] LAST = `IMG_LAST;

    if (IMG_BYTES != 256) begin : g_chk
        $error("IMG_BYTES must be 256 for the 8-bit offset.");
    end

    logic [7:0] mem [0:255];
    logic [1:0] scl_s, sda_s, mode_s, pwr_s, ack_s;
    logic scl_d, sda_d, ack_d, low_r, hpd_oe_r, eeprom_r;
    edid_src_pkg::ddc_state_t st_r;
    logic [3:0] bit_r;
    logic [7:0] rx_r, tx_r, off_r, rdata_r;
    logic oe_r, rw_r, more_r;
    edid_src_pkg::ld_state_t ld_r;
    edid_src_pkg::src_mode_t mode_d_r;
    logic [7:0] cnt_r;
    logic valid_r, req_t_r;
    logic [1:0] lrst_s, req_s;
    logic req_seen_r, bc_req_r, retry_r, ack_t_r;
    logic [7:0] bc_off_r, bc_dev_r;
    edid_src_pkg::bc_result_t res_r;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Bus pins, 5 V and the link acknowledge pass two flip-flops before use; the mode select pins pass three.
    always_ff @(posedge i_clk) begin
        scl_s <= {scl_s[0], i_ddc_scl};
        sda_s <= {sda_s[0], i_ddc_sda};
        mode_s <= {mode_s[0], i_mode_sel[0]};
        pwr_s <= {pwr_s[0], i_pwr5v};
        ack_s <= {ack_s[0], ack_t_r};
        scl_d <= scl_s[1];
        sda_d <= sda_s[1];
        ack_d <= ack_s[1];
    end

    logic [1:0] msel_a, msel_b;
    // The upper select bit gets its own two-stage synchroniser.
    always_ff @(posedge i_clk) begin
        msel_a <= {msel_a[0], i_mode_sel[1]};
        msel_b <= {msel_a[1], mode_s[1]};
    end

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    // Bus events, mode choice and the serve condition.
    wire scl_rise = scl_s[1] & ~scl_d;
    wire scl_fall = ~scl_s[1] & scl_d;
    wire start_w = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire stop_w = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    wire [1:0] pin_mode_w = msel_b;
    wire edid_src_pkg::src_mode_t mode_w = edid_src_pkg::src_mode_t'(
        i_mode_ovr_en ? i_mode_ovr : pin_mode_w);
    wire serve_w = (mode_w != edid_src_pkg::SRC_EEPROM) & valid_r;
    wire addr_hit_w = (rx_r[7:1] == DEV[7:1]);
    wire [7:0] rd_byte_w = mem[off_r];
    wire ack_edge_w = ack_s[1] ^ ack_d;
    wire fetch_ok_w = (ld_r == edid_src_pkg::LD_WAIT) & ack_edge_w & res_r.ok
        & (mode_w == edid_src_pkg::SRC_REMOTE);
    wire ld_wr_w = (ld_r == edid_src_pkg::LD_FUSE) | fetch_ok_w;
    wire [7:0] ld_data_w = (ld_r == edid_src_pkg::LD_FUSE) ? i_fuse_data : res_r.data;
    wire ready_w = pwr_s[1] & i_video_ready
        & (valid_r | (mode_w == edid_src_pkg::SRC_EEPROM));

    // ----------------------------------------------------------------
    // Display data channel slave
    // ----------------------------------------------------------------
    // Start and stop override the byte machine; bits move on clock edges.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r <= edid_src_pkg::DS_IDLE;
            oe_r <= 1'b0;
            bit_r <= 4'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            off_r <= 8'h00;
            rw_r <= 1'b0;
            more_r <= 1'b0;
        end else if (start_w) begin
            st_r <= edid_src_pkg::DS_ADDR;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (stop_w) begin
            st_r <= edid_src_pkg::DS_IDLE;
            oe_r <= 1'b0;
        end else if (scl_rise) begin
            if (st_r == edid_src_pkg::DS_ADDR || st_r == edid_src_pkg::DS_WOFF) begin
                rx_r <= {rx_r[6:0], sda_s[1]};
                bit_r <= bit_r + 4'h1;
            end
            more_r <= ~sda_s[1];
        end else if (scl_fall) begin
            case (st_r)
                edid_src_pkg::DS_ADDR: begin
                    if (bit_r == 4'h8) begin
                        oe_r <= addr_hit_w & serve_w;
                        rw_r <= rx_r[0];
                        st_r <= (addr_hit_w & serve_w) ? edid_src_pkg::DS_AACK
                                                      : edid_src_pkg::DS_SKIP;
                    end
                end
                edid_src_pkg::DS_AACK: begin
                    bit_r <= 4'h0;
                    tx_r <= rd_byte_w;
                    oe_r <= rw_r & ~rd_byte_w[7];
                    st_r <= rw_r ? edid_src_pkg::DS_RDATA : edid_src_pkg::DS_WOFF;
                end
                edid_src_pkg::DS_WOFF: begin
                    if (bit_r == 4'h8) begin
                        off_r <= rx_r;
                        oe_r <= 1'b1;
                        st_r <= edid_src_pkg::DS_WACK;
                    end
                end
                edid_src_pkg::DS_RDATA: begin
                    if (bit_r == 4'h7) begin
                        oe_r <= 1'b0;
                        off_r <= off_r + 8'h01;
                        st_r <= edid_src_pkg::DS_RACK;
                    end else begin
                        bit_r <= bit_r + 4'h1;
                        tx_r <= {tx_r[6:0], 1'b0};
                        oe_r <= ~tx_r[6];
                    end
                end
                edid_src_pkg::DS_RACK: begin
                    bit_r <= 4'h0;
                    tx_r <= rd_byte_w;
                    oe_r <= more_r & ~rd_byte_w[7];
                    st_r <= more_r ? edid_src_pkg::DS_RDATA : edid_src_pkg::DS_SKIP;
                end
                default: begin
                    oe_r <= 1'b0;
                    st_r <= edid_src_pkg::DS_SKIP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Image loader
    // ----------------------------------------------------------------
    // A changed source drops the image; a pending fetch is finished first.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ld_r <= edid_src_pkg::LD_IDLE;
            mode_d_r <= edid_src_pkg::src_mode_t'(`MODE_RST);
            cnt_r <= 8'h00;
            valid_r <= 1'b0;
            req_t_r <= 1'b0;
        end else begin
            mode_d_r <= mode_w;
            if (mode_w != mode_d_r && ld_r != edid_src_pkg::LD_WAIT) begin
                ld_r <= edid_src_pkg::LD_IDLE;
                valid_r <= 1'b0;
                cnt_r <= 8'h00;
            end else begin
                case (ld_r)
                    edid_src_pkg::LD_IDLE: begin
                        cnt_r <= 8'h00;
                        if (mode_w == edid_src_pkg::SRC_SRAM) begin
                            valid_r <= 1'b1;
                        end else if (!valid_r && mode_w == edid_src_pkg::SRC_FUSE) begin
                            ld_r <= edid_src_pkg::LD_FUSE;
                        end else if (!valid_r && mode_w == edid_src_pkg::SRC_REMOTE) begin
                            ld_r <= edid_src_pkg::LD_FETCH;
                        end
                    end
                    edid_src_pkg::LD_FUSE: begin
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r == LAST) begin
                            valid_r <= 1'b1;
                            ld_r <= edid_src_pkg::LD_IDLE;
                        end
                    end
                    edid_src_pkg::LD_FETCH: begin
                        req_t_r <= ~req_t_r;
                        ld_r <= edid_src_pkg::LD_WAIT;
                    end
                    edid_src_pkg::LD_WAIT: begin
                        if (ack_edge_w && mode_w != edid_src_pkg::SRC_REMOTE) begin
                            ld_r <= edid_src_pkg::LD_IDLE;
                        end else if (ack_edge_w && !res_r.ok) begin
                            cnt_r <= 8'h00;
                            ld_r <= edid_src_pkg::LD_FETCH;
                        end else if (fetch_ok_w) begin
                            cnt_r <= cnt_r + 8'h01;
                            valid_r <= (cnt_r == LAST);
                            ld_r <= (cnt_r == LAST) ? edid_src_pkg::LD_IDLE
                                                    : edid_src_pkg::LD_FETCH;
                        end
                    end
                    default: ld_r <= edid_src_pkg::LD_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Image memory and control port
    // ----------------------------------------------------------------
    // The loader has priority; the control port writes and reads back.
    always_ff @(posedge i_clk) begin
        if (ld_wr_w) begin
            mem[cnt_r] <= ld_data_w;
        end else if (i_host_wr) begin
            mem[i_host_addr] <= i_host_wdata;
        end
        rdata_r <= mem[i_host_addr];
    end

    // Hot-plug and pin drivers; hot-plug is driven low until ready.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hpd_oe_r <= 1'b1;
            eeprom_r <= 1'b0;
            low_r <= 1'b0;
        end else begin
            hpd_oe_r <= ~ready_w;
            eeprom_r <= (mode_w == edid_src_pkg::SRC_EEPROM);
            low_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Link clock domain
    // ----------------------------------------------------------------
    // Reset and request toggle are brought over by two flip-flops.
    always_ff @(posedge i_link_clk) begin
        lrst_s <= {lrst_s[0], i_srst};
        req_s <= {req_s[0], req_t_r};
    end

    // One back channel read at a time; a lost arbitration re-requests.
    always_ff @(posedge i_link_clk) begin
        if (lrst_s[1]) begin
            bc_req_r <= 1'b0;
            req_seen_r <= 1'b0;
            retry_r <= 1'b0;
            ack_t_r <= 1'b0;
            bc_off_r <= 8'h00;
            bc_dev_r <= `DDC_DEV_ADDR;
            res_r <= '0;
        end else if (!bc_req_r) begin
            if (retry_r) begin
                bc_req_r <= 1'b1;
                retry_r <= 1'b0;
            end else if (req_s[1] != req_seen_r) begin
                req_seen_r <= req_s[1];
                bc_off_r <= cnt_r;
                bc_dev_r <= `DDC_DEV_ADDR;
                bc_req_r <= 1'b1;
            end
        end else if (i_bc_done) begin
            bc_req_r <= 1'b0;
            retry_r <= i_bc_arb_lost;
            if (!i_bc_arb_lost) begin
                res_r <= '{ok: ~i_bc_nak, data: i_bc_data};
                ack_t_r <= ~ack_t_r;
            end
        end
    end

    assign o_ddc_sda_o = low_r;
    assign o_ddc_sda_oe = oe_r;
    assign o_hpd_o = low_r;
    assign o_hpd_oe = hpd_oe_r;
    assign o_eeprom_en = eeprom_r;
    assign o_img_valid = valid_r;
    assign o_host_rdata = rdata_r;
    assign o_fuse_addr = cnt_r;
    assign o_bc_req = bc_req_r;
    assign o_bc_dev = bc_dev_r;
    assign o_bc_off = bc_off_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_ack_addr;
        @(posedge i_clk) disable iff (i_srst)
        st_r == edid_src_pkg::DS_AACK |-> oe_r && rx_r[7:1] == 7'h50;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("Acked a foreign address.");
    property p_eeprom_quiet;
        @(posedge i_clk) disable iff (i_srst)
        eeprom_r |-> !(st_r inside {edid_src_pkg::DS_AACK, edid_src_pkg::DS_RDATA}) || !oe_r;
    endproperty
    a_eeprom_quiet: assert property (p_eeprom_quiet) else $error("Drove bus in EEPROM mode.");
    property p_ovr;
        @(posedge i_clk) disable iff (i_srst)
        i_mode_ovr_en && $stable(i_mode_ovr) && $stable(i_mode_ovr_en) |=>
            eeprom_r == ($past(i_mode_ovr) == 2'h0);
    endproperty
    a_ovr: assert property (p_ovr) else $error("Override select ignored.");
    property p_fuse_done;
        @(posedge i_clk) disable iff (i_srst)
        ld_r == edid_src_pkg::LD_FUSE && cnt_r == 8'hff && mode_w == mode_d_r |=>
            valid_r && cnt_r == 8'h00;
    endproperty
    a_fuse_done: assert property (p_fuse_done) else $error("Fuse copy length wrong.");
    property p_fetch_step;
        @(posedge i_clk) disable iff (i_srst)
        fetch_ok_w && cnt_r != 8'hff |=> cnt_r == $past(cnt_r) + 8'h01 ##1
            ld_r == edid_src_pkg::LD_WAIT;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("Remote copy did not advance.");
    property p_inc;
        @(posedge i_clk) disable iff (i_srst || start_w || stop_w)
        st_r == edid_src_pkg::DS_RDATA && scl_fall && bit_r == 4'h7 && !start_w && !stop_w
            |=> off_r == $past(off_r) + 8'h01 && st_r == edid_src_pkg::DS_RACK;
    endproperty
    a_inc: assert property (p_inc) else $error("Offset did not advance.");
    property p_hpd;
        @(posedge i_clk) disable iff (i_srst)
        !pwr_s[1] |=> hpd_oe_r;
    endproperty
    a_hpd: assert property (p_hpd) else $error("Hot-plug released without 5 V.");
    property p_host_wr;
        @(posedge i_clk) disable iff (i_srst)
        i_host_wr && !ld_wr_w ##1 !ld_wr_w && !i_host_wr |=>
            rdata_r == $past(i_host_wdata, 2) || $past(i_host_addr) != $past(i_host_addr, 2);
    endproperty
    a_host_wr: assert property (p_host_wr) else $error("Readback mismatch.");
    property p_bc_dev;
        @(posedge i_link_clk) disable iff (lrst_s[1])
        bc_req_r |-> bc_dev_r == 8'ha0 ##1 (!bc_req_r || $stable(bc_off_r));
    endproperty
    a_bc_dev: assert property (p_bc_dev) else $error("Remote read address moved.");
    property p_arb;
        @(posedge i_link_clk) disable iff (lrst_s[1])
        bc_req_r && i_bc_done && i_bc_arb_lost |=> !bc_req_r ##1 bc_req_r;
    endproperty
    a_arb: assert property (p_arb) else $error("Lost arbitration not retried.");
endmodule : edid_source_manager
`default_nettype wire

//--- rtl/edid_src_map.svh
`ifndef EDID_SRC_MAP_SVH
`define EDID_SRC_MAP_SVH
// Display identification slave address on the display data channel.
`define DDC_DEV_ADDR 8'ha0
// Offset of the last byte of the 256-byte image.
`define IMG_LAST 8'hff
// Largest local EEPROM image the source may read while the block stays off the bus.
`define EEPROM_SPAN_BYTES 32768
// Source mode loaded into the mode change detector (mode_d_r) at reset.
`define MODE_RST 2'b00
`endif

//--- rtl/edid_src_pkg.sv
`default_nettype none
package edid_src_pkg;
    typedef enum logic [1:0] {
        SRC_EEPROM = 2'b00,
        SRC_SRAM = 2'b01,
        SRC_REMOTE = 2'b10,
        SRC_FUSE = 2'b11
    } src_mode_t;
    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_AACK = 3'b010,
        DS_WOFF = 3'b011,
        DS_WACK = 3'b100,
        DS_RDATA = 3'b101,
        DS_RACK = 3'b110,
        DS_SKIP = 3'b111
    } ddc_state_t;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_FUSE = 2'b01,
        LD_FETCH = 2'b10,
        LD_WAIT = 2'b11
    } ld_state_t;
    typedef struct packed {
        logic ok;
        logic [7:0] data;
    } bc_result_t;
endpackage : edid_src_pkg
`default_nettype wire

//--- tb/ddc_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Video source model
// ---------------------------------------------------------------
// Owns the 5 V signal and masters the display data channel.
module ddc_source_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_pwr5v
);
    // Bus released and power off until the source starts up.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_pwr5v = 1'b0;
    end
    // Third of a bit of ten core cycles keeps SCL low well past 500 ns.
    task automatic half();
        repeat (10) @(posedge i_clk);
    endtask : half
    // Power is applied before any channel activity is expected.
    task automatic power_up();
        o_pwr5v <= 1'b1;
        half();
    endtask : power_up
    // Start or repeated start: SDA falls while SCL is high.
    task automatic start();
        o_sda_low <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b0;
        half();
    endtask : start
    // Stop: SDA rises while SCL is high, leaving the bus free.
    task automatic stop();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b0;
        half();
    endtask : stop
    // One bit: data set while SCL is low, line sampled just before SCL falls.
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= ~b;
        half();
        o_scl <= 1'b1;
        half();
        r = i_sda;
        o_scl <= 1'b0;
        half();
    endtask : bit_io
    // Eight bits most significant first, then the acknowledge bit.
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : ddc_source_model
`default_nettype wire

//--- tb/edid_source_manager_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// ---------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------
module edid_source_manager_tb;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] mode_sel = 2'b11;
    logic ovr_en = 1'b0;
    logic [1:0] ovr = 2'b00;
    logic video_ready = 1'b0;
    logic host_wr = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [7:0] host_wdata = 8'h00;
    logic bc_done = 1'b0;
    logic bc_arb = 1'b0;
    logic bc_nak = 1'b0;
    int nak_left = 1;
    logic [7:0] bc_data = 8'h00;
    logic [7:0] exp_off = 8'h00;
    int arb_left = 1;
    int miscompares = 0;
    int num_checks = 0;
    logic scl, m_low, pwr5v, sda_o, sda_oe, eeprom_en, img_valid, hpd_o, hpd_oe, bc_req;
    logic [7:0] host_rdata, fuse_addr, bc_dev, bc_off, fuse_data;
    wire sda_line = (sda_oe ? sda_o : 1'b1) & ~m_low;
    // Fuse array answers combinationally from its address.
    assign fuse_data = fuse_addr ^ 8'h5a;
    // Core clock at 10 MHz and a 48 ns link clock started off phase.
    always #50 clk = ~clk;
    initial begin
        #13;
        forever #24 lclk = ~lclk;
    end
    edid_source_manager i_dut (.i_clk(clk), .i_srst(srst), .i_link_clk(lclk),
        .i_ddc_scl(scl), .i_ddc_sda(sda_line), .o_ddc_sda_o(sda_o), .o_ddc_sda_oe(sda_oe),
        .i_mode_sel(mode_sel), .i_mode_ovr_en(ovr_en), .i_mode_ovr(ovr),
        .o_eeprom_en(eeprom_en), .o_img_valid(img_valid), .i_pwr5v(pwr5v),
        .i_video_ready(video_ready), .o_hpd_o(hpd_o), .o_hpd_oe(hpd_oe), .i_host_wr(host_wr),
        .i_host_addr(host_addr), .i_host_wdata(host_wdata), .o_host_rdata(host_rdata),
        .o_fuse_addr(fuse_addr), .i_fuse_data(fuse_data), .o_bc_req(bc_req),
        .o_bc_dev(bc_dev), .o_bc_off(bc_off), .i_bc_done(bc_done), .i_bc_nak(bc_nak),
        .i_bc_arb_lost(bc_arb), .i_bc_data(bc_data));
    ddc_source_model i_src (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(m_low),
        .o_pwr5v(pwr5v));
    // Remote identification device across the back channel; the first request loses
    // arbitration and the next one is refused, so the search restarts from offset zero.
    initial forever begin
        @(negedge lclk);
        if (bc_req === 1'b1) begin
            repeat (2) @(negedge lclk);
            `CHK(bc_off, exp_off)
            `CHK(bc_dev, 8'ha0)
            @(posedge lclk);
            bc_done <= 1'b1;
            bc_arb <= (arb_left != 0);
            bc_nak <= (arb_left == 0) && (nak_left != 0);
            bc_data <= exp_off ^ 8'hc3;
            @(posedge lclk);
            bc_done <= 1'b0;
            bc_arb <= 1'b0;
            bc_nak <= 1'b0;
            bc_data <= ~(exp_off ^ 8'hc3);
            if (arb_left != 0) arb_left--;
            else if (nak_left != 0) nak_left--;
            else exp_off++;
            @(negedge lclk);
            while (bc_req === 1'b1) @(negedge lclk);
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // Waits a bounded time for the image to become valid.
    task automatic wait_valid(input int n);
        for (int i = 0; i < n && img_valid !== 1'b1; i++) @(negedge clk);
        `CHK(img_valid, 1'b1)
    endtask : wait_valid
    // Host port write strobe for one cycle.
    task automatic host_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk);
        host_wr <= 1'b0;
    endtask : host_write
    // Sets the offset, then reads two bytes across a repeated start.
    task automatic ddc_rd(input logic [7:0] off, input logic [15:0] exp);
        logic [7:0] r;
        logic ack;
        i_src.start();
        i_src.xfer(8'ha0, 1'b1, r, ack);
        `CHK(ack, 1'b0)
        i_src.xfer(off, 1'b1, r, ack);
        `CHK(ack, 1'b0)
        i_src.start();
        i_src.xfer(8'ha1, 1'b1, r, ack);
        `CHK(ack, 1'b0)
        i_src.xfer(8'hff, 1'b0, r, ack);
        `CHK(r, exp[15:8])
        i_src.xfer(8'hff, 1'b1, r, ack);
        `CHK(r, exp[7:0])
        i_src.stop();
    endtask : ddc_rd
    // An address the block must not acknowledge.
    task automatic ddc_nak(input logic [7:0] dev);
        logic [7:0] r;
        logic ack;
        i_src.start();
        i_src.xfer(dev, 1'b1, r, ack);
        `CHK(ack, 1'b1)
        i_src.stop();
    endtask : ddc_nak
    // Fuse copy at start-up, hot-plug release, wrap and wrong address.
    task automatic t_fuse();
        `CHK(hpd_oe, 1'b1)
        `CHK(img_valid, 1'b0)
        `CHK(hpd_o, 1'b0)
        `CHK(sda_o, 1'b0)
        `CHK(eeprom_en, 1'b0)
        wait_valid(600);
        `CHK(hpd_oe, 1'b1)
        i_src.power_up();
        video_ready <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK(hpd_oe, 1'b0)
        ddc_rd(8'hff, 16'ha55a);
        ddc_nak(8'ha2);
    endtask : t_fuse
    // SRAM chosen by override, loaded and read back through the host port.
    task automatic t_sram();
        ovr <= 2'b01;
        ovr_en <= 1'b1;
        host_write(8'h10, 8'h3c);
        host_write(8'h11, 8'hc3);
        @(posedge clk);
        @(negedge clk);
        `CHK(host_rdata, 8'hc3)
        wait_valid(20);
        ddc_rd(8'h10, 16'h3cc3);
    endtask : t_sram
    // Local EEPROM chosen by the pins: the block keeps off the bus.
    task automatic t_eeprom();
        ovr_en <= 1'b0;
        mode_sel <= 2'b00;
        repeat (8) @(negedge clk);
        `CHK(eeprom_en, 1'b1)
        `CHK(hpd_oe, 1'b0)
        ddc_nak(8'ha0);
    endtask : t_eeprom
    // Remote fetch of all 256 bytes, then served from the image memory with the remote mode still chosen.
    task automatic t_remote();
        ovr <= 2'b10;
        ovr_en <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK(hpd_oe, 1'b1)
        `CHK(img_valid, 1'b0)
        wait_valid(20000);
        `CHK(exp_off, 8'h00)
        @(posedge clk);
        host_addr <= 8'h07;
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        `CHK(host_rdata, 8'hc4)
        `CHK(hpd_oe, 1'b0)
        ddc_rd(8'h07, 16'hc4cb);
    endtask : t_remote
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        t_fuse();
        t_sram();
        t_eeprom();
        t_remote();
        finish_test();
    end
    // Watchdog against a hang.
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule : edid_source_manager_tb
`default_nettype wire
